// ===== hdl/seac_ctrl.sv
/*
  serial eeprom access controller: ahb-lite register slave, power-up
  autoload, software read and write cycles, strap capture and interrupt.
  assumes straps are steady while rst is high and eeprom data is synchronous.
*/
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "seac_defines.svh"

module seac_ctrl (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // straps, active-low grant pins
  input  wire logic [2:0]            s_gnt_n,
  // eeprom
  input  wire logic                  ee_dat_i,
  output seac_pkg::seac_ee_out_t     ee_out,
  // interrupt
  output logic                       irq
);

  seac_pkg::seac_state_t  state_q;
  seac_pkg::seac_strap_t  strap_q;
  seac_pkg::seac_ee_out_t ee_q;
  logic        start_q, cmd_q, err_q, al_ok_q, al_dis_q, al_pend_q, al_q, op_wr_q;
  logic [1:0]  rate_q;
  logic [7:0]  loc_q;
  logic [15:0] word_q;
  logic [31:0] tx_q;
  logic [15:0] rx_q;
  logic [1:0]  byte_q;
  logic [2:0]  bit_q;
  logic [1:0]  istat_q;
  logic [1:0]  imask_q;
  logic        irq_q;
  logic        wr_pend_q;
  logic [7:0]  waddr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;

  logic        fall, rise, half_rate, busy, sw_go, al_go, launch;
  logic        nack, fin, fin_ok, last_tx;
  logic [2:0]  bsel;
  logic [15:0] rx_next;
  logic        take, wr_ctrl;

  assign busy      = (state_q != seac_pkg::SEAC_IDLE);
  assign al_go     = !busy && al_pend_q && strap_q.bypass;
  assign sw_go     = !busy && !al_pend_q && start_q;
  assign launch    = al_go || sw_go;
  assign half_rate = al_q ? !strap_q.speed : (rate_q == `SEAC_RATE_FAST);
  assign bsel      = strap_q.order ? bit_q : ~bit_q;
  assign last_tx   = (byte_q == (op_wr_q ? `SEAC_LAST_WR_BYTE : `SEAC_LAST_RD_BYTE));
  assign nack      = (state_q == seac_pkg::SEAC_ACK) && rise && ee_dat_i;
  assign fin_ok    = rise && (((state_q == seac_pkg::SEAC_ACK) && !ee_dat_i && last_tx && op_wr_q)
                   || ((state_q == seac_pkg::SEAC_RECV) && (bit_q == 3'h7) && (byte_q == 2'h3)));
  assign fin       = nack || fin_ok;

  always_comb
  begin
    rx_next = rx_q;
    rx_next[{~byte_q[0], bsel}] = ee_dat_i;
  end

  seac_clkdiv u_div (
    .core_clk  (core_clk),
    .rst       (rst),
    .run       (busy),
    .half_rate (half_rate),
    .fall_o    (fall),
    .rise_o    (rise)
  );

  // straps are sampled on every reset cycle, so the last one before release wins
  always_ff @(posedge core_clk)
  begin
    if (rst)
      strap_q <= s_gnt_n;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      al_pend_q <= 1'b1;
      al_dis_q  <= 1'b1;
    end
    else
    begin
      al_dis_q <= !strap_q.bypass;
      if (!busy)
        al_pend_q <= 1'b0;
    end
  end

  // serial sequencer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= seac_pkg::SEAC_IDLE;
      byte_q  <= 2'h0;
      bit_q   <= 3'h0;
      tx_q    <= 32'h0000_0000;
      rx_q    <= 16'h0000;
      al_q    <= 1'b0;
      op_wr_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        seac_pkg::SEAC_IDLE:
        begin
          if (launch)
          begin
            al_q    <= al_go;
            op_wr_q <= !al_go && cmd_q;
            tx_q    <= al_go ? {`SEAC_OP_READ, `SEAC_AL_LOC, 16'h0000}
                             : {(cmd_q ? `SEAC_OP_WRITE : `SEAC_OP_READ), loc_q, word_q};
            byte_q  <= 2'h0;
            bit_q   <= 3'h0;
            state_q <= seac_pkg::SEAC_SEND;
          end
        end
        seac_pkg::SEAC_SEND:
        begin
          if (rise)
          begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7)
              state_q <= seac_pkg::SEAC_ACK;
          end
        end
        seac_pkg::SEAC_ACK:
        begin
          if (fin)
            state_q <= seac_pkg::SEAC_IDLE;
          else if (rise)
          begin
            byte_q  <= byte_q + 2'h1;
            tx_q    <= {tx_q[23:0], 8'h00};
            state_q <= last_tx ? seac_pkg::SEAC_RECV : seac_pkg::SEAC_SEND;
          end
        end
        seac_pkg::SEAC_RECV:
        begin
          if (rise)
          begin
            rx_q  <= rx_next;
            bit_q <= bit_q + 3'h1;
            if (fin)
              state_q <= seac_pkg::SEAC_IDLE;
            else if (bit_q == 3'h7)
              byte_q <= byte_q + 2'h1;
          end
        end
        default:
          state_q <= seac_pkg::SEAC_IDLE;
      endcase
    end
  end

  // pins: data moves on the falling edge, the eeprom samples on the rising one
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ee_q <= '0;
    // the closing rise still reaches the pin, so the eeprom sees its last clock
    else if (!busy)
      ee_q <= '0;
    else if (fall)
    begin
      ee_q.clk    <= 1'b0;
      ee_q.dat_o  <= (state_q == seac_pkg::SEAC_SEND) ? tx_q[{2'b11, bsel}] : 1'b0;
      ee_q.dat_oe <= (state_q == seac_pkg::SEAC_SEND);
    end
    else if (rise)
      ee_q.clk <= 1'b1;
  end

  // ahb-lite: zero wait states, read data registered in the address phase
  assign take    = hsel && htrans[1] && hready;
  assign wr_ctrl = wr_pend_q && (waddr_q == `SEAC_OFF_CTRL) && !start_q && !busy && !al_pend_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_pend_q   <= 1'b0;
      waddr_q     <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      wr_pend_q   <= take && hwrite;
      waddr_q     <= haddr[7:0];
      if (take && !hwrite)
      begin
        case (haddr[7:0])
          `SEAC_OFF_CTRL:  hrdata_q <= {word_q, loc_q, rate_q, 2'b00, al_ok_q, err_q, cmd_q, start_q};
          `SEAC_OFF_TEST:  hrdata_q <= {2'b00, strap_q.order, strap_q.speed, strap_q.bypass,
                                        al_ok_q, 1'b0, al_dis_q, 24'h00_0000};
          `SEAC_OFF_ISTAT: hrdata_q <= {30'h0000_0000, istat_q};
          `SEAC_OFF_IMASK: hrdata_q <= {30'h0000_0000, imask_q};
          default:         hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software fields; writes while a cycle runs are dropped
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
      cmd_q   <= 1'b0;
      rate_q  <= `SEAC_RATE_RST;
      loc_q   <= 8'h00;
      word_q  <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
      begin
        start_q <= hwdata[`SEAC_BIT_START];
        cmd_q   <= hwdata[`SEAC_BIT_CMD];
        rate_q  <= hwdata[7:6];
        loc_q   <= hwdata[15:8];
        word_q  <= hwdata[31:16];
      end
      if (fin && !al_q)
        start_q <= 1'b0;
      // autoload leaves the word field alone
      if (fin_ok && !op_wr_q && !al_q)
        word_q <= rx_next;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      err_q   <= 1'b0;
      al_ok_q <= 1'b0;
    end
    else
    begin
      if (sw_go)
        err_q <= 1'b0;
      if (nack)
        err_q <= 1'b1;
      if (fin_ok && al_q)
        al_ok_q <= 1'b1;
    end
  end

  // interrupt: set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      istat_q <= 2'b00;
      imask_q <= 2'b00;
      irq_q   <= 1'b0;
    end
    else
    begin
      istat_q <= (istat_q & ~((wr_pend_q && (waddr_q == `SEAC_OFF_ISTAT)) ? hwdata[1:0] : 2'b00))
               | {nack, fin_ok};
      if (wr_pend_q && (waddr_q == `SEAC_OFF_IMASK))
        imask_q <= hwdata[1:0];
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign ee_out    = ee_q;
  assign irq       = irq_q;

  chk_start_hold: assert property (@(posedge core_clk) disable iff (rst)
    (busy && !al_q && !fin) |=> start_q) else $error("start dropped before cycle end");
  chk_start_clear: assert property (@(posedge core_clk) disable iff (rst)
    (fin && !al_q) |=> !start_q && !busy) else $error("start not cleared at cycle end");
  chk_cmd_opcode: assert property (@(posedge core_clk) disable iff (rst)
    sw_go |=> tx_q[31:24] == ($past(cmd_q) ? `SEAC_OP_WRITE : `SEAC_OP_READ)) else $error("wrong opcode");
  chk_nack_err: assert property (@(posedge core_clk) disable iff (rst)
    nack |=> err_q && !busy && istat_q[`SEAC_IRQ_ERR]) else $error("nack not flagged");
  chk_autoload_ok: assert property (@(posedge core_clk) disable iff (rst)
    (fin_ok && al_q) |=> al_ok_q && !busy && $stable(word_q)) else $error("autoload status wrong");
  chk_rate_128: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(ee_q.clk) && busy && half_rate && !fin) |-> ##63 !ee_q.clk ##1 ee_q.clk) else $error("clock low time not 64");
  chk_rate_256: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(ee_q.clk) && busy && !half_rate && !fin) |-> ##127 !ee_q.clk ##1 ee_q.clk)
    else $error("clock low time not 128");
  chk_loc_stable: assert property (@(posedge core_clk) disable iff (rst)
    busy |=> $stable(loc_q)) else $error("location changed mid cycle");
  chk_read_word: assert property (@(posedge core_clk) disable iff (rst)
    (fin_ok && !op_wr_q && !al_q) |=> word_q == $past(rx_next)) else $error("read word not stored");
  chk_strap_bypass: assert property (@(posedge core_clk) disable iff (rst)
    (al_pend_q && !strap_q.bypass) |=> !busy [*2]) else $error("autoload ran while bypassed");
  chk_dis_ind: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) |-> al_dis_q == !strap_q.bypass) else $error("disable indicator wrong");

  cov_sw_write: cover property (@(posedge core_clk) disable iff (rst) fin_ok && op_wr_q);
  cov_sw_read:  cover property (@(posedge core_clk) disable iff (rst) fin_ok && !op_wr_q && !al_q);
  cov_nack:     cover property (@(posedge core_clk) disable iff (rst) nack && !al_q);
  cov_autoload: cover property (@(posedge core_clk) disable iff (rst) fin_ok && al_q);

endmodule // seac_ctrl
`default_nettype wire

// ===== hdl/seac_defines.svh
/*
  constants of the serial eeprom access controller: register offsets, field
  positions, reset values, serial command codes and clock divider counts.
  assumes a single core clock and an ahb-lite register bus.
*/
// How it works
// - a start written by software outside autoload runs one eeprom cycle and stays set until that cycle ends.
// - the command bit picks read (0) or write (1) for the next cycle and resets to zero.
// - a missing eeprom acknowledge sets the read-only error flag, which resets to zero.
// - both autoload status bits read one after a successful autoload and zero otherwise.
// - the rate field divides the core clock by 256 (code 01, reset) or 128 (code 10); 00 and 11 are reserved.
// - an eight-bit location field names the eeprom word of the next software cycle.
// - a sixteen-bit word field supplies write data and takes the returned word when a software read ends.
// - the serial bit order is caught from strap pin 2 at reset: zero msb first, one lsb first.
// - the autoload speed is caught from strap pin 1 at reset: zero fast, one normal.
// - the autoload bypass is caught from strap pin 0 at reset: zero skips autoload, one runs it.
// - reserved control and test bits read zero.
`ifndef SEAC_DEFINES_SVH
`define SEAC_DEFINES_SVH

`define SEAC_OFF_CTRL      8'hc8
`define SEAC_OFF_TEST      8'hcc
`define SEAC_OFF_ISTAT     8'hd0
`define SEAC_OFF_IMASK     8'hd4

`define SEAC_BIT_START     0
`define SEAC_BIT_CMD       1
`define SEAC_RATE_RST      2'h1
`define SEAC_RATE_FAST     2'h2
`define SEAC_IRQ_DONE      0
`define SEAC_IRQ_ERR       1

`define SEAC_OP_READ       8'h03
`define SEAC_OP_WRITE      8'h02
`define SEAC_AL_LOC        8'h00
`define SEAC_LAST_WR_BYTE  2'h3
`define SEAC_LAST_RD_BYTE  2'h1

`define SEAC_DIV256_LAST   8'hff
`define SEAC_DIV256_RISE   8'h80
`define SEAC_DIV128_LAST   8'h7f
`define SEAC_DIV128_RISE   8'h40

`endif

// ===== hdl/seac_pkg.sv
/*
  types of the serial eeprom access controller.
  assumes seac_defines.svh is compiled alongside.
*/
package seac_pkg;

  typedef enum logic [3:0] {
    SEAC_IDLE = 4'h1,
    SEAC_SEND = 4'h2,
    SEAC_ACK  = 4'h4,
    SEAC_RECV = 4'h8
  } seac_state_t;

  // eeprom pins driven by the block
  typedef struct packed {
    logic clk;
    logic dat_o;
    logic dat_oe;
  } seac_ee_out_t;

  // straps caught at reset
  typedef struct packed {
    logic order;
    logic speed;
    logic bypass;
  } seac_strap_t;

endpackage

// ===== hdl/seac_clkdiv.sv
/*
  eeprom clock divider: gives one fall and one rise strobe per serial period.
  assumes run stays high for a whole access cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seac_defines.svh"

module seac_clkdiv (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  input  wire logic half_rate,
  // strobes
  output logic      fall_o,
  output logic      rise_o
);

  logic [7:0] cnt_q;
  logic [7:0] last;
  logic [7:0] rise_at;

  assign last    = half_rate ? `SEAC_DIV128_LAST : `SEAC_DIV256_LAST;
  assign rise_at = half_rate ? `SEAC_DIV128_RISE : `SEAC_DIV256_RISE;
  assign fall_o  = run && (cnt_q == 8'h00);
  assign rise_o  = run && (cnt_q == rise_at);

  // restarts at zero so the first strobe of a cycle is a fall
  always_ff @(posedge core_clk)
  begin
    if (rst || !run)
      cnt_q <= 8'h00;
    else if (cnt_q >= last)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

endmodule // seac_clkdiv
`default_nettype wire

// ===== bench/seac_ee_model.sv
/* eeprom partner model: acks each byte, stores writes, returns reads.
   assumes ee_out changes only on core_clk edges. */
`timescale 1ns/1ps
`default_nettype none
`include "seac_defines.svh"

module seac_ee_model (
  // clock
  input  wire logic                   core_clk,
  // block pins
  input  wire seac_pkg::seac_ee_out_t ee_out,
  output logic                        ee_dat_i,
  // test controls
  input  wire logic                   order_lsb,
  input  wire logic                   nack
);
  logic [15:0] mem [256];
  logic [7:0]  byt [4];
  logic        clk_d = 1'b0;
  logic        drv = 1'b0;
  logic        dval = 1'b1;
  int          nb = 0;
  int          quiet = 0;
  logic        wr_end;
  logic        rd_end;

  initial
    foreach (mem[i]) mem[i] = 16'(i) ^ 16'h9c00;

  // pulled-up line: anything released reads high
  assign ee_dat_i = (drv ? dval : 1'b1) & (ee_out.dat_oe ? ee_out.dat_o : 1'b1);
  assign wr_end = nb == 35 && byt[0] == `SEAC_OP_WRITE;
  assign rd_end = nb == 33 && byt[0] == `SEAC_OP_READ;

  always @(posedge core_clk)
  begin
    clk_d <= ee_out.clk;
    quiet <= (ee_out.clk != clk_d) ? 0 : quiet + 1;
    // no clock edge for longer than a period: the frame was cut short
    if (quiet > 300)
      nb <= 0;
    if (ee_out.clk && !clk_d)
    begin
      if (nb % 9 < 8 && nb < 36)
        byt[nb / 9][order_lsb ? nb % 9 : 7 - nb % 9] <= ee_out.dat_o;
      if (wr_end)
        mem[byt[1]] <= {byt[2], byt[3]};
      nb <= (wr_end || rd_end) ? 0 : nb + 1;
    end
    if (!ee_out.clk && clk_d)
    begin
      drv <= 1'b0;
      if (nb % 9 == 8 && (nb < 18 || (nb < 36 && byt[0] == `SEAC_OP_WRITE)))
      begin
        drv <= 1'b1;
        dval <= nack;
      end
      else if (byt[0] == `SEAC_OP_READ && nb >= 18 && nb < 34)
      begin
        drv <= 1'b1;
        dval <= mem[byt[1]][((nb - 18) < 8 ? 8 : 0) + (order_lsb ? (nb - 18) % 8 : 7 - (nb - 18) % 8)];
      end
    end
  end
endmodule // seac_ee_model
`default_nettype wire

// ===== bench/seac_ctrl_bench.sv
/* register-level bench of the eeprom access controller.
   assumes seac_pkg, the design and seac_ee_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "seac_defines.svh"

module seac_ctrl_bench;
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   hsel = 1'b0;
  logic                   hwrite = 1'b0;
  logic [1:0]             htrans = 2'h0;
  logic [2:0]             hsize = 3'h2;
  logic [2:0]             s_gnt_n = 3'h5;
  logic [31:0]            haddr = 32'h0;
  logic [31:0]            hwdata = 32'h0;
  logic                   hreadyout;
  logic                   hresp;
  logic                   irq;
  logic                   ee_dat_i;
  logic [31:0]            hrdata;
  logic [31:0]            rdv;
  logic                   order_lsb = 1'b1;
  logic                   nack = 1'b0;
  logic                   clk_d = 1'b0;
  logic [15:0]            since_rise = 16'h0;
  logic [15:0]            last_period = 16'h0;
  seac_pkg::seac_ee_out_t ee_out;
  int                     n_mismatch = 0;
  int                     samples_checked = 0;

  always #5 core_clk = ~core_clk;

  seac_ctrl dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .s_gnt_n(s_gnt_n), .ee_dat_i(ee_dat_i), .ee_out(ee_out), .irq(irq));

  seac_ee_model ee (.core_clk(core_clk), .ee_out(ee_out), .ee_dat_i(ee_dat_i), .order_lsb(order_lsb),
    .nack(nack));

  // serial period in core cycles, rise to rise
  always @(posedge core_clk)
  begin
    clk_d <= ee_out.clk;
    since_rise <= (ee_out.clk && !clk_d) ? 16'h1 : since_rise + 16'h1;
    if (ee_out.clk && !clk_d)
      last_period <= since_rise;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    rdv = hrdata;
    if (n >= 100)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, rdv);
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  // start is polled, never assumed done, before the next command
  task automatic run_cycle(input logic [31:0] v);
    int n;
    n = 0;
    xfer(1'b1, `SEAC_OFF_CTRL, v);
    xfer(1'b0, `SEAC_OFF_CTRL, 32'h0);
    chk("start held", 32'h1, {31'h0, rdv[0]});
    while (rdv[0] !== 1'b0 && n < 400)
    begin
      repeat (64) @(posedge core_clk);
      xfer(1'b0, `SEAC_OFF_CTRL, 32'h0);
      n++;
    end
    chk("start cleared", 32'h0, {31'h0, rdv[0]});
  endtask

  task automatic do_reset(input logic [2:0] straps);
    s_gnt_n <= straps;
    rst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    int n;
    do_reset(3'h5);
    rd("ctrl reset", `SEAC_OFF_CTRL, 32'h40);
    rd("test straps", `SEAC_OFF_TEST, 32'h2800_0000);
    n = 0;
    while (rdv[26] !== 1'b1 && n < 200)
    begin
      repeat (64) @(posedge core_clk);
      xfer(1'b0, `SEAC_OFF_TEST, 32'h0);
      n++;
    end
    rd("test loaded", `SEAC_OFF_TEST, 32'h2c00_0000);
    rd("ctrl loaded", `SEAC_OFF_CTRL, 32'h48);
    xfer(1'b1, 32'h40, 32'hffff_ffff);
    rd("unmapped", 32'h40, 32'h0);
    xfer(1'b1, `SEAC_OFF_TEST, 32'hffff_ffff);
    rd("test ro", `SEAC_OFF_TEST, 32'h2c00_0000);
    $display("test reset and autoload done");
    run_cycle(32'hbeef_5a83);
    chk("stored word", 32'hbeef, {16'h0, ee.mem[8'h5a]});
    chk("period fast", 32'd128, {16'h0, last_period});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd("done flag", `SEAC_OFF_ISTAT, 32'h1);
    xfer(1'b1, `SEAC_OFF_IMASK, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    xfer(1'b1, `SEAC_OFF_ISTAT, 32'h1);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test write cycle done");
    run_cycle(32'h0000_5a41);
    rd("read word", `SEAC_OFF_CTRL, 32'hbeef_5a48);
    chk("period slow", 32'd256, {16'h0, last_period});
    $display("test read cycle done");
    nack <= 1'b1;
    xfer(1'b1, `SEAC_OFF_IMASK, 32'h3);
    run_cycle(32'h0000_1081);
    rd("nack error", `SEAC_OFF_CTRL, 32'h0000_108c);
    rd("nack flag", `SEAC_OFF_ISTAT, 32'h3);
    chk("irq error", 32'h1, {31'h0, irq});
    nack <= 1'b0;
    xfer(1'b1, `SEAC_OFF_ISTAT, 32'h3);
    // the aborted frame must look finished to the eeprom before the next one
    repeat (400) @(posedge core_clk);
    run_cycle(32'h1234_1083);
    rd("error cleared", `SEAC_OFF_CTRL, 32'h1234_108a);
    $display("test nack done");
    order_lsb <= 1'b0;
    do_reset(3'h2);
    rd("ctrl bypass", `SEAC_OFF_CTRL, 32'h40);
    rd("test bypass", `SEAC_OFF_TEST, 32'h1100_0000);
    run_cycle(32'h5a3c_3383);
    chk("msb word", 32'h5a3c, {16'h0, ee.mem[8'h33]});
    run_cycle(32'h0000_1081);
    rd("msb read", `SEAC_OFF_CTRL, 32'h1234_1080);
    $display("test bit order done");
    tally_and_finish();
  end
endmodule // seac_ctrl_bench
`default_nettype wire
